//--- pkg/stepper_spi_regs.vh
`ifndef STEPPER_SPI_REGS_VH
`define STEPPER_SPI_REGS_VH
// frame and filter sizing
`define WORD_BITS 20
`define FILT_NS 20
`define CLK_NS 4
`define FILT_CYCLES ((`FILT_NS + `CLK_NS - 1) / `CLK_NS)
`define FILT_CNT_W 3
// last count of the filter window, at counter width
`define FILT_LAST 3'h4
`define IN_COUNT 4
// input index in the filter bank
`define IN_SCK 0
`define IN_SDI 1
`define IN_CSN 2
`define IN_ENN 3
// register select field positions
`define SEL_HI 19
`define SEL_MID 18
`define SEL_LO 17
`define SEL3_CHOP 3'h4
`define SEL3_SMART 3'h5
`define SEL3_SGCS 3'h6
`define SEL3_DRVCONF 3'h7
// read select field in the driver configuration word
`define RSEL_HI 5
`define RSEL_LO 4
`define RSEL_STEP 2'h0
`define RSEL_LOAD 2'h1
// reset values
`define WORD_RESET 20'h0_0000
`define FILT_RESET 4'hF
`define IN_SYNC_RESET 4'hF
`endif

//--- hw/stepper_driver_spi_slave.v
`timescale 1ns/1ps
`include "stepper_spi_regs.vh"
module stepper_driver_spi_slave (
  input wire clk,
  input wire srst,
  input wire sck,
  input wire sdi,
  input wire chip_select_n,
  input wire driver_enable_n,
  output wire sdo,
  output wire sdo_oe,
  output reg driver_enable_filt_n,
  input wire [9:0] status_mstep,
  input wire [9:0] status_load,
  input wire [4:0] status_scale,
  input wire [7:0] status_flags,
  output reg [`WORD_BITS-1:0] drvctrl_reg,
  output reg [`WORD_BITS-1:0] chopconf_reg,
  output reg [`WORD_BITS-1:0] smarten_reg,
  output reg [`WORD_BITS-1:0] sgcsconf_reg,
  output reg [`WORD_BITS-1:0] drvconf_reg,
  output reg [`WORD_BITS-1:0] command_reg,
  output reg command_valid,
  output wire [1:0] read_select
);

  reg [`IN_COUNT-1:0] sync1_reg;
  reg [`IN_COUNT-1:0] sync2_reg;
  reg [`IN_COUNT-1:0] filt_reg;
  reg [`IN_COUNT-1:0] filt_prev_reg;
  reg [`FILT_CNT_W-1:0] cnt_reg [0:`IN_COUNT-1];
  reg [`WORD_BITS-1:0] shift_reg;
  reg sdo_reg;
  // next values of the shift path, settled by the combinational block
  reg [`WORD_BITS-1:0] shift_next;
  reg sdo_next;
  // loop index for the per-pin filter bank
  integer i;

  // response word for the selected format
  function [`WORD_BITS-1:0] response;
    input [1:0] sel;
    input [9:0] mstep;
    input [9:0] load;
    input [4:0] scale;
    input [7:0] flags;
    begin
      case (sel)
        `RSEL_STEP: response = {mstep, 2'h0, flags};
        `RSEL_LOAD: response = {load, 2'h0, flags};
        default: response = {load[9:5], scale, 2'h0, flags};
      endcase
    end
  endfunction

  // rising edge of a filtered level against its copy one clock older
  function rise_of;
    input now;
    input prev;
    begin
      rise_of = now & ~prev;
    end
  endfunction

  // falling edge of a filtered level against its copy one clock older
  function fall_of;
    input now;
    input prev;
    begin
      fall_of = ~now & prev;
    end
  endfunction

  // edge flags of the filtered inputs
  wire sck_rise = rise_of(filt_reg[`IN_SCK], filt_prev_reg[`IN_SCK]);
  wire sck_fall = fall_of(filt_reg[`IN_SCK], filt_prev_reg[`IN_SCK]);
  wire cs_fall = fall_of(filt_reg[`IN_CSN], filt_prev_reg[`IN_CSN]);
  wire cs_rise = rise_of(filt_reg[`IN_CSN], filt_prev_reg[`IN_CSN]);
  wire cs_active = ~filt_reg[`IN_CSN];

  // read select and output pins; enable follows the filtered select only
  assign read_select = drvconf_reg[`RSEL_HI:`RSEL_LO];
  assign sdo = sdo_reg;
  assign sdo_oe = cs_active;

  // response captured when select falls; status is same-clock, no sync
  wire [`WORD_BITS-1:0] resp_word = response(read_select, status_mstep, status_load,
    status_scale, status_flags);

  // target decode of the word about to be latched; bit 19 low means drive word
  wire [2:0] sel_code = shift_reg[`SEL_HI:`SEL_LO];
  wire hit_drvctrl = ~shift_reg[`SEL_HI];
  wire hit_chop = (sel_code == `SEL3_CHOP);
  wire hit_smart = (sel_code == `SEL3_SMART);
  wire hit_sgcs = (sel_code == `SEL3_SGCS);
  wire hit_drvconf = (sel_code == `SEL3_DRVCONF);

  // two-stage synchroniser on every pin
  // reset to ones so idle-high pins give no false edge after reset
  // only the second stage is read further on
  always @(posedge clk) begin
    if (srst) begin
      sync1_reg <= `IN_SYNC_RESET;
      sync2_reg <= `IN_SYNC_RESET;
    end else begin
      sync1_reg <= {driver_enable_n, chip_select_n, sdi, sck};
      sync2_reg <= sync1_reg;
    end
  end

  // accept a new level only after it has held the full filter time
  // any bounce back to the old level restarts the count
  always @(posedge clk) begin
    if (srst) begin
      filt_reg <= `FILT_RESET;
      filt_prev_reg <= `FILT_RESET;
      for (i = 0; i < `IN_COUNT; i = i + 1) begin
        cnt_reg[i] <= {`FILT_CNT_W{1'b0}};
      end
    end else begin
      filt_prev_reg <= filt_reg;
      for (i = 0; i < `IN_COUNT; i = i + 1) begin
        if (sync2_reg[i] == filt_reg[i]) begin
          cnt_reg[i] <= {`FILT_CNT_W{1'b0}};
        end else if (cnt_reg[i] == `FILT_LAST) begin
          cnt_reg[i] <= {`FILT_CNT_W{1'b0}};
          filt_reg[i] <= sync2_reg[i];
        end else begin
          cnt_reg[i] <= cnt_reg[i] + 1'b1;
        end
      end
    end
  end

  // filtered driver enable
  // shares the pin filter; the extra flop keeps the output registered
  // so a short low pulse on the pin never reaches the motor stage
  always @(posedge clk) begin
    if (srst) begin
      driver_enable_filt_n <= 1'b1;
    end else begin
      driver_enable_filt_n <= filt_reg[`IN_ENN];
    end
  end

  // shift path next values: status preload, sample on rise, drive on fall
  always @* begin
    shift_next = shift_reg;
    sdo_next = sdo_reg;
    if (cs_fall) begin
      shift_next = resp_word;
      sdo_next = resp_word[`WORD_BITS-1];
    end else if (cs_active && sck_rise) begin
      shift_next = {shift_reg[`WORD_BITS-2:0], filt_reg[`IN_SDI]};
    end else if (cs_active && sck_fall) begin
      sdo_next = shift_reg[`WORD_BITS-1];
    end
  end

  // shift path registers; clock edges while deselected change nothing
  always @(posedge clk) begin
    if (srst) begin
      shift_reg <= `WORD_RESET;
      sdo_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      sdo_reg <= sdo_next;
    end
  end

  // latch the last word on chip select release and decode its target
  // every upper code is decoded, so no word is dropped silently
  // the pulse marks the cycle in which the new words appear
  always @(posedge clk) begin
    if (srst) begin
      command_reg <= `WORD_RESET;
      command_valid <= 1'b0;
      drvctrl_reg <= `WORD_RESET;
      chopconf_reg <= `WORD_RESET;
      smarten_reg <= `WORD_RESET;
      sgcsconf_reg <= `WORD_RESET;
      drvconf_reg <= `WORD_RESET;
    end else begin
      command_valid <= cs_rise;
      if (cs_rise) begin
        command_reg <= shift_reg;
        if (hit_drvctrl) begin
          drvctrl_reg <= shift_reg;
        end
        if (hit_chop) begin
          chopconf_reg <= shift_reg;
        end
        if (hit_smart) begin
          smarten_reg <= shift_reg;
        end
        if (hit_sgcs) begin
          sgcsconf_reg <= shift_reg;
        end
        if (hit_drvconf) begin
          drvconf_reg <= shift_reg;
        end
      end
    end
  end

endmodule // stepper_driver_spi_slave

//--- tb/spi_checker.sv
`timescale 1ns/1ps
module spi_checker (input wire clk, input wire srst, input wire chip_select_n,
  input wire sdo_oe, input wire command_valid, input wire [19:0] drvconf_reg,
  input wire driver_enable_n, input wire driver_enable_filt_n);
  // clk domain, off in reset
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  oe_idle_a: assert property (chip_select_n [*8] |=> !sdo_oe) else $error("oe");
  oe_sel_a: assert property (!chip_select_n [*8] |=> sdo_oe) else $error("oe");
  oe_up_a: assert property ($rose(sdo_oe) |-> !$past(chip_select_n, 5))
    else $error("up");
  oe_down_a: assert property ($fell(sdo_oe) |-> $past(chip_select_n, 5))
    else $error("down");
  cv_once_a: assert property (command_valid |=> !command_valid) else $error("cv");
  cv_src_a: assert property (
    command_valid |-> !sdo_oe && ($past(sdo_oe) || $past(sdo_oe, 2))) else $error("src");
  cv_pin_a: assert property (command_valid |-> $past(chip_select_n, 7))
    else $error("pin");
  conf_upd_a: assert property ($changed(drvconf_reg) |-> command_valid)
    else $error("conf");
  enn_fall_a: assert property ($fell(driver_enable_filt_n) |->
    !$past(driver_enable_n, 4) && !$past(driver_enable_n, 8)) else $error("enn fall");
  enn_rise_a: assert property ($rose(driver_enable_filt_n) |->
    $past(driver_enable_n, 4) && $past(driver_enable_n, 8)) else $error("enn rise");
  cover property (command_valid);
  cover property ($fell(driver_enable_filt_n));
  cover property ($rose(sdo_oe));
  cover property ($fell(sdo_oe));
endmodule // spi_checker
bind stepper_driver_spi_slave spi_checker chk (.clk, .srst, .chip_select_n, .sdo_oe,
  .command_valid, .drvconf_reg, .driver_enable_n, .driver_enable_filt_n);

//--- tb/spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (input wire clk, input wire sdo, output reg sck = 1'b1,
  output reg sdi = 1'b1, output reg chip_select_n = 1'b1);
  // short low pulse on chip select, under the filter window
  task cs_glitch(input int n);
    chip_select_n <= 1'b0;
    repeat (n) @(posedge clk);
    chip_select_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
  // mode 3 frame, msb first, sck period 16 clk, far under half clk
  task xfer(input int n, input logic [39:0] d, output logic [39:0] q);
    q = 40'h0;
    chip_select_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      sck <= 1'b0;
      sdi <= d[i];
      repeat (8) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      q[i] = sdo;
      repeat (4) @(posedge clk);
    end
    chip_select_n <= 1'b1;
    sdi <= ~sdi; // no stale bit
    repeat (12) @(posedge clk);
  endtask
endmodule // spi_master_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg srst = 1'b1;
  wire sck, sdi, chip_select_n, sdo;
  wire [1:0] read_select;
  wire [19:0] drvctrl_reg, drvconf_reg, chopconf_reg, smarten_reg, sgcsconf_reg;
  wire [19:0] command_reg;
  wire sdo_oe, command_valid, driver_enable_filt_n;
  reg driver_enable_n = 1'b1;
  int n_cmd = 0;
  logic [39:0] rx;
  int n_mismatch = 0, comparisons = 0;
  // clock, design, serial master
  initial forever #2 clk = ~clk;
  stepper_driver_spi_slave dut (.clk, .srst, .sck, .sdi, .chip_select_n, .sdo,
    .driver_enable_n, .status_mstep(10'h2a5), .status_load(10'h1c3),
    .status_scale(5'h15), .status_flags(8'h96), .sdo_oe, .driver_enable_filt_n,
    .drvctrl_reg, .chopconf_reg, .smarten_reg, .sgcsconf_reg, .drvconf_reg,
    .command_reg, .command_valid, .read_select);
  // count of command pulses
  always @(posedge clk) if (command_valid) n_cmd <= n_cmd + 1;
  spi_master_model m (.clk, .sdo, .sck, .sdi, .chip_select_n);
  task chk(input logic [39:0] g, input logic [39:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h", $time, g);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // 40 clocks: first word passes through, last is kept
  task t_chain;
    m.xfer(40, {20'h1_2345, 20'he_0010}, rx);
    chk(rx, {10'h2a5, 2'h0, 8'h96, 20'h1_2345});
    chk({drvctrl_reg, drvconf_reg}, {20'h0, 20'he_0010});
    $display("t_chain done");
  endtask
  // load format, then scale format with a drive word
  task t_sel;
    m.xfer(20, 40'he_0020, rx);
    chk(rx, {10'h1c3, 2'h0, 8'h96});
    m.xfer(20, 40'h1_2345, rx);
    chk({rx, read_select}, {5'h0e, 5'h15, 2'h0, 8'h96, 2'h2});
    chk(drvctrl_reg, 20'h1_2345);
    $display("t_sel done");
  endtask
  // one word to each remaining target, one pulse per frame
  task t_regs;
    int c0;
    c0 = n_cmd;
    m.xfer(20, 40'h8_1234, rx);
    chk(rx, {5'h0e, 5'h15, 2'h0, 8'h96});
    m.xfer(20, 40'ha_0567, rx);
    m.xfer(20, 40'hc_0a9b, rx);
    chk({chopconf_reg, smarten_reg}, {20'h8_1234, 20'ha_0567});
    chk({sgcsconf_reg, command_reg}, {20'hc_0a9b, 20'hc_0a9b});
    chk({drvconf_reg, drvctrl_reg}, {20'he_0020, 20'h1_2345});
    chk(n_cmd - c0, 3);
    $display("t_regs done");
  endtask
  // pulses under the filter window change nothing; long ones pass
  task t_filt;
    int c0;
    c0 = n_cmd;
    m.cs_glitch(3);
    chk(n_cmd - c0, 0);
    chk(sdo_oe, 0);
    driver_enable_n <= 1'b0;
    repeat (3) @(posedge clk);
    driver_enable_n <= 1'b1;
    repeat (12) @(posedge clk);
    chk(driver_enable_filt_n, 1);
    driver_enable_n <= 1'b0;
    repeat (12) @(posedge clk);
    chk(driver_enable_filt_n, 0);
    driver_enable_n <= 1'b1;
    repeat (12) @(posedge clk);
    chk(driver_enable_filt_n, 1);
    $display("t_filt done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (10) @(posedge clk);
    t_chain;
    t_sel;
    t_regs;
    t_filt;
    end_of_test;
  end
  // hang guard
  initial begin
    #20000;
    n_mismatch++;
    end_of_test;
  end
endmodule // testbench
